// ### src/buffered_pwm_channel_pair.sv
// buffered_pwm_channel_pair: counter, prescaler and two output-compare pwm channels that
// can be linked into one buffered pwm output on the channel 0 pin.
// assumes one 200 MHz clock, synchronous active-low reset, avalon-mm master on the same clock.
//
// Contract
// [RULE_01] channel 0 mode-high bit links both channels into one buffered pwm on pin 0
// [RULE_02] after linking, channel 0 compare value sets the pulse width first
// [RULE_03] writing channel 1 compare hands control to it at next period start
// [RULE_04] at each overflow the most recently written compare pair becomes active
// [RULE_05] while linked, channel 0 control governs and reports; channel 1 control ignored
// [RULE_06] while linked, channel 1 pin is released to general-purpose use
// [RULE_07] software writes new widths only to the inactive compare pair
// [RULE_08] writing the active pair updates immediately, like unbuffered pwm
// [RULE_09] software halts the counter, then resets counter and prescaler first
// [RULE_10] with counter halted, software loads period and compare values
// [RULE_11] mode field 0:1 selects unbuffered, 1:0 selects buffered compare or pwm
// [RULE_12] toggle-on-overflow set to 1 toggles the output at each overflow
// [RULE_13] edge/level 1:0 clears on match, 1:1 sets on match
// [RULE_14] software should avoid toggle-on-compare for pwm channels
// [RULE_15] software clears the halt bit last to start pwm generation
// [RULE_16] counter counts up on prescaled clock, wraps to zero after the modulo value
`timescale 1ns/1ps
`default_nettype none

module buffered_pwm_channel_pair #(
	parameter int CNT_W = pwm_pair_pkg::CNT_W,
	parameter int PRE_W = pwm_pair_pkg::PRE_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [pwm_pair_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic ch0_output_pin_o,
	output logic ch0_output_oe_o,
	output logic ch1_output_pin_o,
	output logic ch1_output_oe_o,
	output logic overflow_o
);

	typedef struct packed {
		pwm_pair_pkg::bus_state_t bus;
		logic [31:0] rdata;
		logic halt;
		logic [2:0] ps;
		logic [PRE_W-1:0] pre;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] period;
		logic [1:0] mode_hi;
		logic [1:0] mode_lo;
		logic [1:0] el_hi;
		logic [1:0] el_lo;
		logic [1:0] tov;
		logic [CNT_W-1:0] cmp0;
		logic [CNT_W-1:0] cmp1;
		logic [1:0] out;
		logic active;
		logic last_written;
		logic ovf;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic req;
	logic wr_fire;
	logic linked;
	logic tick;
	logic [PRE_W-1:0] pre_mask;
	logic [31:0] wmask;
	logic ovf_now;
	wire logic [1:0] chan_en;
	wire logic [1:0] chan_match;
	wire logic [1:0] pin_nxt;
	wire logic [1:0] chan_el [2];
	wire logic [CNT_W-1:0] chan_width [2];

	assign req = avs_read_i | avs_write_i;
	// a request is acknowledged one cycle after it is first seen
	assign avs_waitrequest_o = req & (st_r.bus != pwm_pair_pkg::BUS_ACK);
	assign wr_fire = avs_write_i & (st_r.bus == pwm_pair_pkg::BUS_ACK);
	assign linked = st_r.mode_hi[0]; // [RULE_01]
	assign pre_mask = PRE_W'((1 << st_r.ps) - 1);
	assign tick = ~st_r.halt & ((st_r.pre & pre_mask) == pre_mask);
	// wrap marks the period boundary for toggles and for the pair handover
	assign ovf_now = tick & (st_r.cnt == st_r.period); // [RULE_16]
	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	assign avs_readdata_o = st_r.rdata;
	assign ch0_output_pin_o = st_r.out[0];
	assign ch1_output_pin_o = st_r.out[1];
	assign overflow_o = st_r.ovf;

	// timer owns a pin only while its channel is in a compare or pwm mode
	assign ch0_output_oe_o = st_r.mode_hi[0] | st_r.mode_lo[0];
	assign ch1_output_oe_o = ~linked & st_r.mode_lo[1]; // [RULE_06]

	function automatic logic [31:0] read_word(input state_t s, input logic [4:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			pwm_pair_pkg::OFS_TIMER_CTL: begin
				d[pwm_pair_pkg::TSC_HALT] = s.halt;
				d[pwm_pair_pkg::TSC_PS_LSB +: 3] = s.ps;
			end
			pwm_pair_pkg::OFS_COUNTER: d[CNT_W-1:0] = s.cnt;
			pwm_pair_pkg::OFS_PERIOD: d[CNT_W-1:0] = s.period;
			pwm_pair_pkg::OFS_CH0_CTL: begin
				// linked pair state is reported here only
				d[pwm_pair_pkg::CSC_ACTIVE] = s.mode_hi[0] & s.active; // [RULE_05]
				d[pwm_pair_pkg::CSC_MODE_HI] = s.mode_hi[0];
				d[pwm_pair_pkg::CSC_MODE_LO] = s.mode_lo[0];
				d[pwm_pair_pkg::CSC_EL_HI] = s.el_hi[0];
				d[pwm_pair_pkg::CSC_EL_LO] = s.el_lo[0];
				d[pwm_pair_pkg::CSC_TOV] = s.tov[0];
			end
			pwm_pair_pkg::OFS_CH0_CMP: d[CNT_W-1:0] = s.cmp0;
			pwm_pair_pkg::OFS_CH1_CTL: begin
				d[pwm_pair_pkg::CSC_MODE_LO] = s.mode_lo[1];
				d[pwm_pair_pkg::CSC_EL_HI] = s.el_hi[1];
				d[pwm_pair_pkg::CSC_EL_LO] = s.el_lo[1];
				d[pwm_pair_pkg::CSC_TOV] = s.tov[1];
			end
			pwm_pair_pkg::OFS_CH1_CMP: d[CNT_W-1:0] = s.cmp1;
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	// next pin level of one channel; a wrap toggle wins over a same-tick match
	function automatic logic chan_pin(input logic en, input logic wrap, input logic tov,
		input logic match, input logic [1:0] el, input logic cur);
		logic p;
		p = cur;
		if (!en) begin
			p = 1'b0;
		end else if (wrap && tov) begin
			p = ~cur; // [RULE_12]
		end else if (match) begin
			case (el)
				pwm_pair_pkg::EL_CLEAR: p = 1'b0; // [RULE_13]
				pwm_pair_pkg::EL_SET: p = 1'b1; // [RULE_13]
				// kept for plain compare use; a pwm setup should not pick it
				pwm_pair_pkg::EL_TOGGLE: p = ~cur;
				default: p = cur;
			endcase
		end
		return p;
	endfunction

	// one compare unit per channel; the lead channel follows the linked pair
	for (genvar c = 0; c < 2; c++) begin : g_chan
		if (c == 0) begin : g_lead
			assign chan_en[c] = st_r.mode_hi[0] | st_r.mode_lo[0]; // [RULE_11]
			assign chan_width[c] = (linked && st_r.active) ? st_r.cmp1 : st_r.cmp0; // [RULE_02]
		end else begin : g_follow
			// a linked pair leaves channel 1 control with no say over any pin
			assign chan_en[c] = ~linked & st_r.mode_lo[1]; // [RULE_05]
			assign chan_width[c] = st_r.cmp1;
		end
		assign chan_el[c] = {st_r.el_hi[c], st_r.el_lo[c]};
		assign chan_match[c] = tick & (st_r.cnt == chan_width[c]);
		assign pin_nxt[c] = chan_pin(chan_en[c], ovf_now, st_r.tov[c], chan_match[c],
			chan_el[c], st_r.out[c]);
	end

	always_comb begin
		logic [31:0] wd;
		wd = 32'h0000_0000;
		st_nxt = st_r;
		st_nxt.ovf = 1'b0;

		case (st_r.bus)
			pwm_pair_pkg::BUS_IDLE: begin
				if (req) begin
					st_nxt.bus = pwm_pair_pkg::BUS_ACK;
					st_nxt.rdata = avs_read_i ? read_word(st_r, avs_address_i) : 32'h0000_0000;
				end
			end
			pwm_pair_pkg::BUS_ACK: st_nxt.bus = pwm_pair_pkg::BUS_IDLE;
			default: st_nxt.bus = pwm_pair_pkg::BUS_IDLE;
		endcase

		// prescaler and counter
		if (!st_r.halt) begin
			st_nxt.pre = st_r.pre + PRE_W'(1);
		end
		if (tick) begin
			if (ovf_now) begin
				st_nxt.cnt = pwm_pair_pkg::RST_CNT; // [RULE_16]
			end else begin
				st_nxt.cnt = st_r.cnt + CNT_W'(1); // [RULE_16]
			end
		end
		st_nxt.ovf = ovf_now;

		// both pins register together so they never skew against each other
		st_nxt.out = pin_nxt;

		// register writes take effect at the edge where waitrequest is seen low
		if (wr_fire) begin
			case (avs_address_i)
				pwm_pair_pkg::OFS_TIMER_CTL: if (avs_byteenable_i[0]) begin
					st_nxt.halt = avs_writedata_i[pwm_pair_pkg::TSC_HALT];
					st_nxt.ps = avs_writedata_i[pwm_pair_pkg::TSC_PS_LSB +: 3];
					if (avs_writedata_i[pwm_pair_pkg::TSC_CNT_RST]) begin
						st_nxt.cnt = pwm_pair_pkg::RST_CNT; // [RULE_09]
						st_nxt.pre = pwm_pair_pkg::RST_PRE; // [RULE_09]
					end
				end
				pwm_pair_pkg::OFS_PERIOD: begin
					wd = {16'h0000, st_r.period};
					wd = (wd & ~wmask) | (avs_writedata_i & wmask);
					st_nxt.period = wd[CNT_W-1:0]; // [RULE_10]
				end
				pwm_pair_pkg::OFS_CH0_CTL: if (avs_byteenable_i[0]) begin
					st_nxt.mode_hi[0] = avs_writedata_i[pwm_pair_pkg::CSC_MODE_HI];
					st_nxt.mode_lo[0] = avs_writedata_i[pwm_pair_pkg::CSC_MODE_LO];
					st_nxt.el_hi[0] = avs_writedata_i[pwm_pair_pkg::CSC_EL_HI];
					st_nxt.el_lo[0] = avs_writedata_i[pwm_pair_pkg::CSC_EL_LO];
					st_nxt.tov[0] = avs_writedata_i[pwm_pair_pkg::CSC_TOV];
					// a fresh link always starts from the channel 0 pair
					if (avs_writedata_i[pwm_pair_pkg::CSC_MODE_HI] && !linked) begin
						st_nxt.active = 1'b0; // [RULE_02]
						st_nxt.last_written = 1'b0; // [RULE_02]
					end
				end
				pwm_pair_pkg::OFS_CH0_CMP: begin
					wd = {16'h0000, st_r.cmp0};
					wd = (wd & ~wmask) | (avs_writedata_i & wmask);
					st_nxt.cmp0 = wd[CNT_W-1:0]; // [RULE_08]
					st_nxt.last_written = 1'b0; // [RULE_04]
				end
				pwm_pair_pkg::OFS_CH1_CTL: if (avs_byteenable_i[0]) begin
					// mode-high does not exist on channel 1
					st_nxt.mode_lo[1] = avs_writedata_i[pwm_pair_pkg::CSC_MODE_LO];
					st_nxt.el_hi[1] = avs_writedata_i[pwm_pair_pkg::CSC_EL_HI];
					st_nxt.el_lo[1] = avs_writedata_i[pwm_pair_pkg::CSC_EL_LO];
					st_nxt.tov[1] = avs_writedata_i[pwm_pair_pkg::CSC_TOV];
				end
				pwm_pair_pkg::OFS_CH1_CMP: begin
					wd = {16'h0000, st_r.cmp1};
					wd = (wd & ~wmask) | (avs_writedata_i & wmask);
					st_nxt.cmp1 = wd[CNT_W-1:0]; // [RULE_08]
					if (linked) begin
						st_nxt.last_written = 1'b1; // [RULE_03]
					end
				end
				default: st_nxt.halt = st_r.halt;
			endcase
		end

		// handover only at a period boundary; a write in the same cycle counts as latest
		if (linked && st_nxt.ovf) begin
			st_nxt.active = st_nxt.last_written; // [RULE_03] [RULE_04]
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_r.bus <= pwm_pair_pkg::BUS_IDLE;
			st_r.rdata <= 32'h0000_0000;
			st_r.halt <= pwm_pair_pkg::RST_HALT;
			st_r.ps <= pwm_pair_pkg::RST_PS;
			st_r.pre <= pwm_pair_pkg::RST_PRE;
			st_r.cnt <= pwm_pair_pkg::RST_CNT;
			st_r.period <= pwm_pair_pkg::RST_PERIOD;
			st_r.mode_hi <= 2'h0;
			st_r.mode_lo <= 2'h0;
			st_r.el_hi <= 2'h0;
			st_r.el_lo <= 2'h0;
			st_r.tov <= 2'h0;
			st_r.cmp0 <= pwm_pair_pkg::RST_CMP;
			st_r.cmp1 <= pwm_pair_pkg::RST_CMP;
			st_r.out <= 2'h0;
			st_r.active <= 1'b0;
			st_r.last_written <= 1'b0;
			st_r.ovf <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

`default_nettype wire

// ### src/pwm_pair_pkg.sv
// pwm_pair_pkg: register map, field positions and reset values of the buffered pwm pair.
// assumes a 32-bit avalon-mm slave port with word-aligned byte addresses.
package pwm_pair_pkg;

	localparam int ADDR_W = 5;
	localparam int CNT_W = 16;
	localparam int PRE_W = 7;

	// byte offsets of the word registers
	localparam logic [4:0] OFS_TIMER_CTL = 5'h00;
	localparam logic [4:0] OFS_COUNTER = 5'h04;
	localparam logic [4:0] OFS_PERIOD = 5'h08;
	localparam logic [4:0] OFS_CH0_CTL = 5'h0C;
	localparam logic [4:0] OFS_CH0_CMP = 5'h10;
	localparam logic [4:0] OFS_CH1_CTL = 5'h14;
	localparam logic [4:0] OFS_CH1_CMP = 5'h18;

	// timer_status_control fields
	localparam int TSC_HALT = 5;
	localparam int TSC_CNT_RST = 4;
	localparam int TSC_PS_LSB = 0;

	// channel status/control fields
	localparam int CSC_ACTIVE = 6;
	localparam int CSC_MODE_HI = 5;
	localparam int CSC_MODE_LO = 4;
	localparam int CSC_EL_HI = 3;
	localparam int CSC_EL_LO = 2;
	localparam int CSC_TOV = 1;

	// mode select and edge/level encodings (hi:lo)
	localparam logic [1:0] MODE_UNBUF = 2'h1;
	localparam logic [1:0] MODE_BUF = 2'h2;
	localparam logic [1:0] EL_TOGGLE = 2'h1;
	localparam logic [1:0] EL_CLEAR = 2'h2;
	localparam logic [1:0] EL_SET = 2'h3;

	// values after reset
	localparam logic RST_HALT = 1'h1;
	localparam logic [2:0] RST_PS = 3'h0;
	localparam logic [CNT_W-1:0] RST_PERIOD = 16'hFFFF;
	localparam logic [CNT_W-1:0] RST_CMP = 16'h0000;
	localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
	localparam logic [PRE_W-1:0] RST_PRE = 7'h00;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} bus_state_t;

endpackage

// ### testbench/buffered_pwm_channel_pair_props.sv
// checker: bus handshake, pin enables and counter behaviour of the pwm pair
// assumes it is bound to buffered_pwm_channel_pair; shadows control writes seen on the bus
`timescale 1ns/1ps
`default_nettype none
module pwm_pair_props #(
	parameter int CNT_W = pwm_pair_pkg::CNT_W,
	parameter int PRE_W = pwm_pair_pkg::PRE_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [pwm_pair_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic ch0_output_pin_o,
	input wire logic ch0_output_oe_o,
	input wire logic ch1_output_pin_o,
	input wire logic ch1_output_oe_o,
	input wire logic overflow_o
);
	typedef struct packed {logic halt; logic link; logic [1:0] mode;} shadow_t;
	shadow_t sh_r;
	shadow_t sh_nxt;
	logic wr_ok;
	logic rd_ok;
	assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	assign rd_ok = avs_read_i && !avs_waitrequest_o;
	always_comb begin
		sh_nxt = sh_r;
		if (wr_ok && avs_address_i == pwm_pair_pkg::OFS_TIMER_CTL) begin
			sh_nxt.halt = avs_writedata_i[pwm_pair_pkg::TSC_HALT];
		end
		if (wr_ok && avs_address_i == pwm_pair_pkg::OFS_CH0_CTL) begin
			sh_nxt.link = avs_writedata_i[pwm_pair_pkg::CSC_MODE_HI];
			sh_nxt.mode = avs_writedata_i[5:4];
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			sh_r <= 4'h8;
		end else begin
			sh_r <= sh_nxt;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_wait_first: assert property (
		$rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o) else $error("no wait state");
	chk_wait_one: assert property (
		avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait state too long");
	chk_link_release: assert property (
		sh_r.link |-> !ch1_output_oe_o) else $error("pin 1 still driven while linked");
	chk_pin0_enable: assert property (
		ch0_output_oe_o == (sh_r.mode != 2'h0)) else $error("pin 0 enable wrong");
	chk_ch1_hidden: assert property (
		rd_ok && avs_address_i == pwm_pair_pkg::OFS_CH1_CTL |-> !avs_readdata_o[5])
		else $error("ch1 mode high visible");
	chk_active_unlinked: assert property (
		rd_ok && avs_address_i == pwm_pair_pkg::OFS_CH0_CTL && !sh_r.link
		|-> !avs_readdata_o[pwm_pair_pkg::CSC_ACTIVE]) else $error("active pair set unlinked");
	chk_halt_no_ovf: assert property (
		sh_r.halt && $past(sh_r.halt) && $past(sh_r.halt, 2) && $past(sh_r.halt, 3)
		|-> !overflow_o) else $error("overflow while halted");
	chk_pin_frozen: assert property (
		sh_r.halt && $past(sh_r.halt) && !$past(avs_write_i) && !$past(avs_write_i, 2)
		|-> $stable(ch0_output_pin_o)) else $error("pin 0 moved while halted");
endmodule
bind buffered_pwm_channel_pair pwm_pair_props #(.CNT_W(CNT_W), .PRE_W(PRE_W)) i_pwm_pair_props (
	.sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
	.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .ch0_output_pin_o,
	.ch0_output_oe_o, .ch1_output_pin_o, .ch1_output_oe_o, .overflow_o);
`default_nettype wire

// ### testbench/tb_buffered_pwm_channel_pair.sv
// testbench: register access and pwm waveforms of the linked channel pair
// assumes the checker is bound in; the bench is the avalon-mm master itself
`timescale 1ns/1ps
`default_nettype none
module tb_buffered_pwm_channel_pair;
	typedef struct {logic [31:0] ctl; logic [31:0] cmp; int high;} row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h00000000;
	logic [3:0] be = 4'hF;
	logic [31:0] q;
	logic [31:0] rdat;
	logic wt, p0, oe0, p1, oe1, ovf;
	int fails = 0;
	int n_compared = 0;
	// high cycles counted over two periods of four cycles; no row toggles on match
	row_t rows[4] = '{
		'{32'h0000001A, 32'h00000001, 4},
		'{32'h0000001A, 32'h00000002, 6},
		'{32'h0000001E, 32'h00000002, 2},
		'{32'h0000002A, 32'h00000001, 4}};
	always #2.5 clk = ~clk;
	buffered_pwm_channel_pair i_buffered_pwm_channel_pair (.sys_clk_i(clk), .rst_n_i(rst_n),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
		.ch0_output_pin_o(p0), .ch0_output_oe_o(oe0), .ch1_output_pin_o(p1),
		.ch1_output_oe_o(oe1), .overflow_o(ovf));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wt !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic pwm_high(input int exp);
		int n;
		int w;
		n = 0;
		w = 0;
		repeat (8) begin
			@(negedge clk);
			n += (p0 === 1'b1);
			w += (ovf === 1'b1);
		end
		chk(32'(n), 32'(exp));
		chk(32'(w), 32'h2);
	endtask
	task automatic settle;
		repeat (12) @(posedge clk);
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 5'h00, 32'h00000030);
			bus(1'b1, 5'h08, 32'h00000003);
			bus(1'b1, 5'h10, rows[i].cmp);
			bus(1'b1, 5'h0C, rows[i].ctl);
			bus(1'b1, 5'h00, 32'h00000000);
			settle();
			pwm_high(rows[i].high);
			$display("row %0d done", i);
		end
		chk(32'(oe1), 32'h0);
		bus(1'b1, 5'h18, 32'h00000002);
		settle();
		pwm_high(6);
		bus(1'b0, 5'h0C, 32'h0);
		chk(q & 32'h40, 32'h40);
		bus(1'b1, 5'h14, 32'h0000001E);
		settle();
		pwm_high(6);
		chk(32'(oe1), 32'h0);
		chk(32'(p1), 32'h0);
		bus(1'b1, 5'h10, 32'h00000000);
		settle();
		pwm_high(2);
		bus(1'b1, 5'h10, 32'h00000002);
		settle();
		pwm_high(6);
		$display("handover test done");
		bus(1'b0, 5'h1C, 32'h0);
		chk(q, 32'h0);
		be <= 4'h0;
		bus(1'b1, 5'h08, 32'h00000005);
		be <= 4'hF;
		bus(1'b0, 5'h08, 32'h0);
		chk(q, 32'h00000003);
		$display("bus refusal test done");
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 5'h00, 32'h0);
		chk(q, 32'h00000020);
		bus(1'b0, 5'h08, 32'h0);
		chk(q, 32'h0000FFFF);
		chk({30'h0, oe0, p0}, 32'h0);
		$display("reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
